//--- hdl/pmt_consts.svh
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// Register offsets on the plain register port
`define PMT_ADDR_START 4'h0
`define PMT_ADDR_MODE 4'h1
`define PMT_ADDR_COUNT 4'h2
`define PMT_ADDR_TRIG 4'h3
`define PMT_ADDR_IRQ 4'h4
`define PMT_ADDR_PRE 4'h5

// Field positions
`define PMT_RUN_LSB 5
`define PMT_RUN_MSB 7
`define PMT_MODE_OP_LSB 0
`define PMT_MODE_EDGE_LSB 2
`define PMT_MODE_OVF_BIT 5
`define PMT_MODE_SRC_LSB 6
`define PMT_TRIG_EN_LSB 2
`define PMT_TRIG_SEL_BIT 4
`define PMT_IRQ_FLAG_BIT 3
`define PMT_PRE_F2_BIT 0

// Reset and count values
`define PMT_STATE_RST '0
`define PMT_CNT_ZERO 16'h0000
`define PMT_CNT_MAX 16'hffff
`define PMT_CNT_ONE 16'h0001

// Prescaler terminal counts
`define PMT_PRE_ONE 5'h01
`define PMT_DIV2_MASK 5'h01
`define PMT_DIV8_MASK 5'h07
`define PMT_DIV32_MASK 5'h1f

`endif

//--- hdl/pmt_pkg.sv
package pmt_pkg;

    typedef enum logic [1:0] {
        PMT_OP_TIMER = 2'b00,
        PMT_OP_EVENT = 2'b01,
        PMT_OP_MEASURE = 2'b10,
        PMT_OP_RSVD = 2'b11
    } pmt_op_e;

    typedef enum logic [1:0] {
        PMT_EDGE_FALL = 2'b00,
        PMT_EDGE_RISE = 2'b01,
        PMT_EDGE_WIDTH = 2'b10,
        PMT_EDGE_RSVD = 2'b11
    } pmt_edge_e;

    typedef enum logic [1:0] {
        PMT_SRC_F1F2 = 2'b00,
        PMT_SRC_F8 = 2'b01,
        PMT_SRC_F32 = 2'b10,
        PMT_SRC_SUB_CLOCK_DIV32 = 2'b11
    } pmt_src_e;

    typedef struct packed {
        pmt_op_e op;
        pmt_edge_e edge_sel;
        pmt_src_e src;
        logic [2:0] run;
        logic ovf;
        logic ovf_aged;
        logic [1:0] trig_en;
        logic trig_sel;
        logic f2_sel;
        logic irq_flag;
        logic [15:0] counter;
        logic [15:0] reload;
        logic first_seen;
        logic active;
        logic pin_q;
        logic adc_start;
        logic [15:0] rdata;
        logic [4:0] pre_cnt;
    } pmt_state_s;

endpackage

//--- hdl/pmt_timer.sv
// The address map and the plain strobed port were chosen for this implementation.
`include "pmt_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pmt_timer #(
    parameter int CH = 0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [15:0] bus_rdata,
    // Pins and neighbour events
    input wire logic measurement_input_pin,
    input wire logic sub_clock_div32_tick,
    input wire logic tb2_event,
    input wire logic rate_counter_underflow,
    input wire logic irq_accept,
    // Results
    output logic interrupt_request_flag,
    output logic overflow_flag,
    output logic adc_start
);

    localparam bit ADC_OK = (CH < 2);
    localparam int CH_IDX = ADC_OK ? CH : 0;

    pmt_pkg::pmt_state_s s_ff;
    pmt_pkg::pmt_state_s nxt_s;

    logic run_me;
    logic src_tick;
    logic count_tick;
    logic pin_rise;
    logic pin_fall;
    logic eff_edge;
    logic is_meas;
    logic adc_mode;
    logic trig_pulse;
    logic trig_go;
    logic meas_edge;
    logic ovf_evt;
    logic uf_evt;
    logic irq_req;
    logic wr_count;
    logic wr_mode;
    logic rd_count;

    assign run_me = s_ff.run[CH];
    assign is_meas = (s_ff.op == pmt_pkg::PMT_OP_MEASURE);
    assign adc_mode = ADC_OK && (s_ff.op == pmt_pkg::PMT_OP_TIMER) && s_ff.trig_en[CH_IDX];

    // Free prescaler; divided sources are single-cycle enables, not clocks
    always_comb begin
        case (s_ff.src)
            pmt_pkg::PMT_SRC_F1F2: src_tick = s_ff.f2_sel ? ((s_ff.pre_cnt & `PMT_DIV2_MASK) == `PMT_DIV2_MASK) : 1'b1;
            pmt_pkg::PMT_SRC_F8: src_tick = ((s_ff.pre_cnt & `PMT_DIV8_MASK) == `PMT_DIV8_MASK);
            pmt_pkg::PMT_SRC_F32: src_tick = (s_ff.pre_cnt == `PMT_DIV32_MASK);
            default: src_tick = sub_clock_div32_tick;
        endcase
    end

    assign count_tick = run_me && src_tick;

    assign pin_rise = measurement_input_pin && !s_ff.pin_q;
    assign pin_fall = !measurement_input_pin && s_ff.pin_q;

    // Reserved edge code never captures, so the channel just free-runs
    always_comb begin
        case (s_ff.edge_sel)
            pmt_pkg::PMT_EDGE_FALL: eff_edge = pin_fall;
            pmt_pkg::PMT_EDGE_RISE: eff_edge = pin_rise;
            pmt_pkg::PMT_EDGE_WIDTH: eff_edge = pin_rise || pin_fall;
            default: eff_edge = 1'b0;
        endcase
    end

    assign meas_edge = run_me && is_meas && eff_edge;
    assign ovf_evt = count_tick && is_meas && !eff_edge && (s_ff.counter == `PMT_CNT_MAX);
    assign uf_evt = s_ff.active && adc_mode && count_tick && (s_ff.counter == `PMT_CNT_ZERO);
    assign trig_pulse = s_ff.trig_sel ? rate_counter_underflow : tb2_event;
    assign trig_go = run_me && adc_mode && trig_pulse && !s_ff.active;
    assign irq_req = (meas_edge && s_ff.first_seen) || ovf_evt || uf_evt;
    assign wr_count = bus_write && (bus_addr == `PMT_ADDR_COUNT);
    assign wr_mode = bus_write && (bus_addr == `PMT_ADDR_MODE);
    assign rd_count = bus_read && (bus_addr == `PMT_ADDR_COUNT);

    always_comb begin
        nxt_s = s_ff;
        nxt_s.adc_start = 1'b0;
        nxt_s.rdata = `PMT_CNT_ZERO;
        nxt_s.pin_q = measurement_input_pin;
        nxt_s.pre_cnt = s_ff.pre_cnt + `PMT_PRE_ONE;
        if (!run_me) begin
            nxt_s.first_seen = 1'b0;
            nxt_s.active = 1'b0;
        end
        // Leaving A/D trigger mode drops a countdown, so no stale start pulse follows later
        if (!adc_mode) begin
            nxt_s.active = 1'b0;
        end
        if (is_meas) begin
            if (meas_edge) begin
                nxt_s.reload = s_ff.counter;
                nxt_s.counter = `PMT_CNT_ZERO;
                nxt_s.first_seen = 1'b1;
            end else if (count_tick) begin
                nxt_s.counter = s_ff.counter + `PMT_CNT_ONE;
            end
        end else if (s_ff.active && count_tick) begin
            if (uf_evt) begin
                nxt_s.counter = s_ff.reload;
                nxt_s.active = 1'b0;
                nxt_s.adc_start = 1'b1;
            end else begin
                nxt_s.counter = s_ff.counter - `PMT_CNT_ONE;
            end
        end
        if (trig_go) begin
            nxt_s.active = 1'b1;
        end
        // The overflow flag only becomes clearable once a count tick has passed since it was set
        if (s_ff.ovf && count_tick) begin
            nxt_s.ovf_aged = 1'b1;
        end
        if (bus_write) begin
            if (bus_addr == `PMT_ADDR_START) begin
                nxt_s.run = bus_wdata[`PMT_RUN_MSB:`PMT_RUN_LSB];
            end else if (bus_addr == `PMT_ADDR_MODE) begin
                nxt_s.op = pmt_pkg::pmt_op_e'(bus_wdata[`PMT_MODE_OP_LSB +: 2]);
                nxt_s.edge_sel = pmt_pkg::pmt_edge_e'(bus_wdata[`PMT_MODE_EDGE_LSB +: 2]);
                nxt_s.src = pmt_pkg::pmt_src_e'(bus_wdata[`PMT_MODE_SRC_LSB +: 2]);
                if (s_ff.ovf_aged && run_me) begin
                    nxt_s.ovf = 1'b0;
                    nxt_s.ovf_aged = 1'b0;
                end
            end else if (bus_addr == `PMT_ADDR_COUNT) begin
                if (!is_meas) begin
                    nxt_s.reload = bus_wdata;
                    if (!s_ff.active) begin
                        nxt_s.counter = bus_wdata;
                    end
                end
            end else if (bus_addr == `PMT_ADDR_TRIG) begin
                nxt_s.trig_en = bus_wdata[`PMT_TRIG_EN_LSB +: 2];
                nxt_s.trig_sel = bus_wdata[`PMT_TRIG_SEL_BIT];
            end else if (bus_addr == `PMT_ADDR_IRQ) begin
                if (!bus_wdata[`PMT_IRQ_FLAG_BIT]) begin
                    nxt_s.irq_flag = 1'b0;
                end
            end else if (bus_addr == `PMT_ADDR_PRE) begin
                nxt_s.f2_sel = bus_wdata[`PMT_PRE_F2_BIT];
            end
        end
        if (irq_accept) begin
            nxt_s.irq_flag = 1'b0;
        end
        // Set beats clear so no event is lost against a software clear
        if (irq_req) begin
            nxt_s.irq_flag = 1'b1;
        end
        if (ovf_evt) begin
            nxt_s.ovf = 1'b1;
            nxt_s.ovf_aged = 1'b0;
        end
        if (bus_read) begin
            if (bus_addr == `PMT_ADDR_START) begin
                nxt_s.rdata = {8'h00, s_ff.run, 5'h00};
            end else if (bus_addr == `PMT_ADDR_MODE) begin
                nxt_s.rdata = {8'h00, s_ff.src, s_ff.ovf, 1'b0, s_ff.edge_sel, s_ff.op};
            end else if (bus_addr == `PMT_ADDR_COUNT) begin
                nxt_s.rdata = is_meas ? s_ff.reload : s_ff.counter;
            end else if (bus_addr == `PMT_ADDR_TRIG) begin
                nxt_s.rdata = {11'h000, s_ff.trig_sel, s_ff.trig_en, 2'h0};
            end else if (bus_addr == `PMT_ADDR_IRQ) begin
                nxt_s.rdata = {12'h000, s_ff.irq_flag, 3'h0};
            end else if (bus_addr == `PMT_ADDR_PRE) begin
                nxt_s.rdata = {15'h0000, s_ff.f2_sel};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= `PMT_STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign bus_rdata = s_ff.rdata;
    assign interrupt_request_flag = s_ff.irq_flag;
    assign overflow_flag = s_ff.ovf;
    assign adc_start = s_ff.adc_start;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_armed;
        s_ff.active;
    endsequence

    sequence s_fire;
        !s_ff.active && s_ff.adc_start;
    endsequence

    property p_run_hold;
        is_meas && !run_me && !meas_edge |=> $stable(s_ff.counter);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("counter moved while stopped");

    property p_capture;
        meas_edge |=> (s_ff.reload == $past(s_ff.counter)) && (s_ff.counter == `PMT_CNT_ZERO);
    endproperty
    a_capture: assert property (p_capture) else $error("edge capture wrong");

    property p_first_quiet;
        meas_edge && !s_ff.first_seen && !s_ff.irq_flag |=> !s_ff.irq_flag;
    endproperty
    a_first_quiet: assert property (p_first_quiet) else $error("first edge raised request");

    property p_later_edge;
        meas_edge && s_ff.first_seen |=> s_ff.irq_flag;
    endproperty
    a_later_edge: assert property (p_later_edge) else $error("edge missed request");

    property p_overflow;
        ovf_evt |=> s_ff.ovf && s_ff.irq_flag && (s_ff.counter == `PMT_CNT_ZERO);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_ovf_clear;
        wr_mode && s_ff.ovf_aged && run_me && !ovf_evt |=> !s_ff.ovf;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

    property p_ovf_young;
        wr_mode && s_ff.ovf && !s_ff.ovf_aged |=> s_ff.ovf;
    endproperty
    a_ovf_young: assert property (p_ovf_young) else $error("overflow cleared too early");

    property p_meas_read;
        rd_count && is_meas |=> bus_rdata == $past(s_ff.reload);
    endproperty
    a_meas_read: assert property (p_meas_read) else $error("measure read not reload");

    property p_meas_write;
        wr_count && is_meas && !meas_edge && !count_tick |=> $stable(s_ff.reload) && $stable(s_ff.counter);
    endproperty
    a_meas_write: assert property (p_meas_write) else $error("measure write took effect");

    property p_irq_ack;
        irq_accept && !irq_req |=> !s_ff.irq_flag;
    endproperty
    a_irq_ack: assert property (p_irq_ack) else $error("accept did not clear flag");

    property p_no_adc_ch2;
        !ADC_OK |-> !s_ff.active && !s_ff.adc_start;
    endproperty
    a_no_adc_ch2: assert property (p_no_adc_ch2) else $error("channel without A/D mode fired");

    property p_underflow;
        uf_evt |=> s_fire and (s_ff.counter == $past(s_ff.reload)) and s_ff.irq_flag;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow did not reload and stop");

    property p_ignore_trig;
        s_ff.active && run_me && adc_mode && trig_pulse && !count_tick && !wr_count
            |=> $stable(s_ff.counter) and s_armed;
    endproperty
    a_ignore_trig: assert property (p_ignore_trig) else $error("trigger disturbed countdown");

    property p_zero_ratio;
        trig_go && (s_ff.counter == `PMT_CNT_ZERO) && (s_ff.src == pmt_pkg::PMT_SRC_F1F2) && !s_ff.f2_sel
            && !bus_write |=> s_armed ##1 s_fire;
    endproperty
    a_zero_ratio: assert property (p_zero_ratio) else $error("zero count did not fire after one tick");

    property p_start;
        trig_go |=> s_armed;
    endproperty
    a_start: assert property (p_start) else $error("trigger did not start countdown");

    property p_stop;
        !run_me |=> !s_ff.active;
    endproperty
    a_stop: assert property (p_stop) else $error("countdown survived run clear");

    property p_live_read;
        rd_count && !is_meas |=> bus_rdata == $past(s_ff.counter);
    endproperty
    a_live_read: assert property (p_live_read) else $error("live read wrong");

    property p_write_idle;
        wr_count && !is_meas && !s_ff.active |=> (s_ff.counter == $past(bus_wdata)) && (s_ff.reload == $past(bus_wdata));
    endproperty
    a_write_idle: assert property (p_write_idle) else $error("stopped write not loaded");

    property p_write_busy;
        wr_count && !is_meas && s_ff.active && !count_tick |=> $stable(s_ff.counter)
            && (s_ff.reload == $past(bus_wdata));
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("busy write reached counter");

    property p_meas_count;
        count_tick && is_meas && !eff_edge |=> s_ff.counter == $past(s_ff.counter) + `PMT_CNT_ONE;
    endproperty
    a_meas_count: assert property (p_meas_count) else $error("measure counter not counting up");

    property p_adc_pulse;
        s_fire |=> !s_ff.adc_start;
    endproperty
    a_adc_pulse: assert property (p_adc_pulse) else $error("start pulse longer than one cycle");

    property p_sw_clear;
        bus_write && (bus_addr == `PMT_ADDR_IRQ) && !bus_wdata[`PMT_IRQ_FLAG_BIT] && !irq_req
            |=> !s_ff.irq_flag;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("software write did not clear flag");

endmodule

`default_nettype wire

//--- test/pmt_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_far_end (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pulse shape
    input wire logic pulse_en,
    input wire logic [15:0] lo_len,
    input wire logic [15:0] hi_len,
    // Converter side and pulse pin
    input wire logic adc_start,
    output logic pin,
    output logic [7:0] conversions
);
    logic [15:0] cnt;
    // Rests high so each burst opens with a full high phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 1'b1;
            cnt <= 16'h0000;
        end else if (!pulse_en || cnt >= (pin ? hi_len : lo_len) - 16'h0001) begin
            pin <= pulse_en ? ~pin : 1'b1;
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
    // One conversion per start pulse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conversions <= 8'h00;
        end else if (adc_start) begin
            conversions <= conversions + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"
module tb;
    logic clock, rst_n, bus_write, bus_read, tb2_event, rate_uf, irq_accept;
    logic sub_tick, pulse_en, wr_ch1;
    logic [3:0] bus_addr;
    logic [2:0] sub_cnt;
    logic [15:0] bus_wdata, lo_len, hi_len;
    wire logic [15:0] bus_rdata;
    wire logic irq_flag, ovf_flag, adc_start, pin, adc_start1, adc_start2;
    wire logic [7:0] conversions;
    int mismatches, tests_run, cycles;

    pmt_timer #(.CH(0)) DUT (
        .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
        .measurement_input_pin(pin), .sub_clock_div32_tick(sub_tick),
        .tb2_event(tb2_event), .rate_counter_underflow(rate_uf), .irq_accept(irq_accept),
        .interrupt_request_flag(irq_flag), .overflow_flag(ovf_flag), .adc_start(adc_start)
    );
    // Neighbour channels see only writes made while wr_ch1 is high
    pmt_timer #(.CH(1)) DUT1 (
        .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write && wr_ch1), .bus_read(bus_read), .bus_rdata(),
        .measurement_input_pin(pin), .sub_clock_div32_tick(sub_tick),
        .tb2_event(tb2_event), .rate_counter_underflow(rate_uf), .irq_accept(irq_accept),
        .interrupt_request_flag(), .overflow_flag(), .adc_start(adc_start1)
    );
    pmt_timer #(.CH(2)) DUT2 (
        .clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write && wr_ch1), .bus_read(bus_read), .bus_rdata(),
        .measurement_input_pin(pin), .sub_clock_div32_tick(sub_tick),
        .tb2_event(tb2_event), .rate_counter_underflow(rate_uf), .irq_accept(irq_accept),
        .interrupt_request_flag(), .overflow_flag(), .adc_start(adc_start2)
    );
    pmt_far_end far (
        .clock(clock), .rst_n(rst_n), .pulse_en(pulse_en), .lo_len(lo_len),
        .hi_len(hi_len), .adc_start(adc_start), .pin(pin), .conversions(conversions)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Stands in for the sub-clock divider, one tick in eight
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sub_cnt <= 3'h0;
            sub_tick <= 1'b0;
        end else begin
            sub_cnt <= sub_cnt + 3'h1;
            sub_tick <= sub_cnt == 3'h7;
        end
    end
    // Overflow scenario alone needs about 66k cycles
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycles <= 0;
        end else begin
            cycles <= cycles + 1;
            if (cycles == 90000) begin
                mismatches++;
                finish_test();
            end
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clock);
        bus_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clock);
        bus_read <= 1'b0;
        #1 d = bus_rdata;
        @(posedge clock);
    endtask
    task automatic trig(input logic sel);
        tb2_event <= !sel;
        rate_uf <= sel;
        @(posedge clock);
        tb2_event <= 1'b0;
        rate_uf <= 1'b0;
    endtask
    task automatic t_reset;
        logic [15:0] d;
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0], d);
            chk("reset_reg", d, 0);
        end
    endtask
    task automatic t_meas(input logic [15:0] mode, pre, lo, hi, input logic irq1,
                          input logic [15:0] emin, emax);
        logic [15:0] d, d2;
        wr(`PMT_ADDR_START, 16'h0000);
        wr(`PMT_ADDR_PRE, pre);
        wr(`PMT_ADDR_MODE, mode);
        wr(`PMT_ADDR_IRQ, 16'h0000);
        lo_len <= lo;
        hi_len <= hi;
        pulse_en <= 1'b1;
        @(negedge pin);
        wr(`PMT_ADDR_START, 16'h0020);
        @(negedge pin);
        repeat (3) @(posedge clock);
        #1 chk("first_edge_irq", irq_flag, irq1);
        @(negedge pin);
        repeat (3) @(posedge clock);
        #1 chk("edge_irq", irq_flag, 1);
        @(posedge clock);
        // First capture is never judged, it may be stale
        rd(`PMT_ADDR_COUNT, d);
        chk("capture", d >= emin && d <= emax, 1);
        wr(`PMT_ADDR_COUNT, 16'h1234);
        rd(`PMT_ADDR_COUNT, d2);
        chk("write_ignored", d2, d);
        pulse_en <= 1'b0;
        wr(`PMT_ADDR_START, 16'h0000);
    endtask
    task automatic t_ovf;
        int k;
        wr(`PMT_ADDR_MODE, 16'h0000);
        wr(`PMT_ADDR_PRE, 16'h0000);
        wr(`PMT_ADDR_COUNT, 16'h0000);
        wr(`PMT_ADDR_MODE, 16'h0002);
        wr(`PMT_ADDR_IRQ, 16'h0000);
        wr(`PMT_ADDR_START, 16'h0020);
        k = 0;
        while (ovf_flag !== 1'b1 && k < 70000) begin
            @(posedge clock);
            #1 k++;
        end
        chk("ovf_time", k >= 65530 && k <= 65538, 1);
        chk("ovf_irq", irq_flag, 1);
        @(posedge clock);
        // Run bit stays set across the clearing write
        wr(`PMT_ADDR_MODE, 16'h0002);
        #1 chk("ovf_clear", ovf_flag, 0);
        @(posedge clock);
        irq_accept <= 1'b1;
        @(posedge clock);
        irq_accept <= 1'b0;
        @(posedge clock);
        #1 chk("irq_accept", irq_flag, 0);
        @(posedge clock);
        // Second overflow on a slow source: a write before the next tick must not clear
        wr(`PMT_ADDR_MODE, 16'h0000);
        wr(`PMT_ADDR_COUNT, 16'hfffe);
        wr(`PMT_ADDR_MODE, 16'h0042);
        k = 0;
        while (ovf_flag !== 1'b1 && k < 40) begin
            @(posedge clock);
            #1 k++;
        end
        wr(`PMT_ADDR_MODE, 16'h0042);
        #1 chk("ovf_young", ovf_flag, 1);
        repeat (10) @(posedge clock);
        wr(`PMT_ADDR_MODE, 16'h0042);
        #1 chk("ovf_late_clear", ovf_flag, 0);
        @(posedge clock);
        wr(`PMT_ADDR_START, 16'h0000);
    endtask
    task automatic t_rsvd;
        logic [15:0] d, d2;
        wr(`PMT_ADDR_IRQ, 16'h0000);
        wr(`PMT_ADDR_MODE, 16'h000e);
        rd(`PMT_ADDR_COUNT, d);
        lo_len <= 16'd10;
        hi_len <= 16'd10;
        pulse_en <= 1'b1;
        wr(`PMT_ADDR_START, 16'h0020);
        repeat (60) @(posedge clock);
        rd(`PMT_ADDR_COUNT, d2);
        chk("rsvd_no_capture", d2, d);
        chk("rsvd_no_irq", irq_flag, 0);
        pulse_en <= 1'b0;
        wr(`PMT_ADDR_START, 16'h0000);
    endtask
    task automatic t_delay;
        int k, k0;
        logic fired2;
        k0 = 0;
        fired2 = 1'b0;
        wr_ch1 <= 1'b1;
        wr(`PMT_ADDR_START, 16'h0000);
        wr(`PMT_ADDR_MODE, 16'h0000);
        wr(`PMT_ADDR_TRIG, 16'h000c);
        // Channel 1 keeps the longer delay
        wr(`PMT_ADDR_COUNT, 16'h0009);
        wr_ch1 <= 1'b0;
        wr(`PMT_ADDR_COUNT, 16'h0004);
        wr_ch1 <= 1'b1;
        wr(`PMT_ADDR_START, 16'h00e0);
        trig(1'b0);
        k = 0;
        while (adc_start1 !== 1'b1 && k < 20) begin
            @(posedge clock);
            #1 k++;
            if (adc_start === 1'b1) begin
                k0 = k;
            end
            if (adc_start2 !== 1'b0) begin
                fired2 = 1'b1;
            end
        end
        chk("ch0_delay", k0, 5);
        chk("ch1_delay", k, 10);
        chk("ch2_no_adc", fired2, 0);
        wr(`PMT_ADDR_START, 16'h0000);
    endtask
    task automatic t_adc(input logic [15:0] n, input logic sel, mid);
        logic [15:0] d;
        logic [7:0] c0;
        int k;
        wr(`PMT_ADDR_START, 16'h0000);
        wr(`PMT_ADDR_MODE, 16'h0000);
        wr(`PMT_ADDR_COUNT, n);
        wr(`PMT_ADDR_TRIG, sel ? 16'h0014 : 16'h0004);
        wr(`PMT_ADDR_IRQ, 16'h0000);
        wr(`PMT_ADDR_START, 16'h0020);
        rd(`PMT_ADDR_COUNT, d);
        chk("stopped_load", d, n);
        c0 = conversions;
        trig(!sel);
        repeat (n + 6) @(posedge clock);
        chk("wrong_source", conversions, c0);
        trig(sel);
        k = 0;
        if (mid) begin
            rd(`PMT_ADDR_COUNT, d);
            chk("live_count", d <= n && d >= n - 16'h0002, 1);
            trig(sel);
            wr(`PMT_ADDR_COUNT, 16'h0007);
            k = 5;
        end
        while (adc_start !== 1'b1 && k < n + 10) begin
            @(posedge clock);
            #1 k++;
        end
        chk("fire_delay", k, n + 1);
        chk("fire_irq", irq_flag, 1);
        @(posedge clock);
        rd(`PMT_ADDR_COUNT, d);
        chk("reloaded", d, mid ? 16'h0007 : n);
        chk("conversions", conversions, c0 + 8'h01);
        wr(`PMT_ADDR_IRQ, 16'h0000);
        #1 chk("irq_sw_clear", irq_flag, 0);
        @(posedge clock);
    endtask
    task automatic t_block;
        logic [7:0] c0;
        c0 = conversions;
        wr(`PMT_ADDR_TRIG, 16'h0000);
        trig(1'b0);
        repeat (10) @(posedge clock);
        chk("no_enable", conversions, c0);
        wr(`PMT_ADDR_TRIG, 16'h0004);
        trig(1'b0);
        wr(`PMT_ADDR_START, 16'h0000);
        repeat (20) @(posedge clock);
        chk("run_cleared", conversions, c0);
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        {rst_n, bus_write, bus_read, tb2_event, rate_uf, irq_accept, pulse_en} = '0;
        {wr_ch1, bus_addr, bus_wdata} = '0;
        lo_len = 16'h0020;
        hi_len = 16'h0020;
        mismatches = 0;
        tests_run = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_meas(16'h0002, 16'h0000, 16'd30, 16'd20, 1'b0, 16'd49, 16'd49);
        t_meas(16'h0006, 16'h0000, 16'd30, 16'd20, 1'b0, 16'd49, 16'd49);
        t_meas(16'h000a, 16'h0000, 16'd30, 16'd20, 1'b1, 16'd19, 16'd19);
        t_meas(16'h0002, 16'h0001, 16'd64, 16'd64, 1'b0, 16'd63, 16'd64);
        t_meas(16'h0042, 16'h0000, 16'd64, 16'd64, 1'b0, 16'd15, 16'd16);
        t_meas(16'h0082, 16'h0000, 16'd128, 16'd128, 1'b0, 16'd7, 16'd8);
        t_meas(16'h00c2, 16'h0000, 16'd64, 16'd64, 1'b0, 16'd15, 16'd16);
        t_rsvd();
        t_ovf();
        t_adc(16'h0000, 1'b0, 1'b0);
        t_adc(16'h0003, 1'b1, 1'b0);
        t_adc(16'h0014, 1'b0, 1'b1);
        t_block();
        t_delay();
        finish_test();
    end
endmodule
`default_nettype wire
